// *** hdl/dalu_map.svh ***
// Constants for the data arithmetic unit: widths, selectors, saturation values.
// Assumes inclusion by the unit's design file only.
`ifndef DALU_MAP_SVH
`define DALU_MAP_SVH
`define DALU_WORD_W 24
`define DALU_EXT_W 8
`define DALU_ACC_W 56
`define DALU_PROD_W 48
`define DALU_SAT_POS 24'h7fffff
`define DALU_SAT_NEG 24'h800000
`define DALU_SAT_POS48 48'h7fffffffffff
`define DALU_SAT_NEG48 48'h800000000000
`define DALU_MAC_CYCLES 2
// Register selectors on the operand buses
`define DALU_SEL_X0 4'h0
`define DALU_SEL_X1 4'h1
`define DALU_SEL_Y0 4'h2
`define DALU_SEL_Y1 4'h3
`define DALU_SEL_A0 4'h4
`define DALU_SEL_A1 4'h5
`define DALU_SEL_A2 4'h6
`define DALU_SEL_B0 4'h7
`define DALU_SEL_B1 4'h8
`define DALU_SEL_B2 4'h9
`define DALU_SEL_A 4'ha
`define DALU_SEL_B 4'hb
`define DALU_SEL_X 4'hc
`define DALU_SEL_Y 4'hd
`endif

// *** hdl/dalu_pkg.sv ***
// Types of the data arithmetic unit.
// Assumes the constants header is compiled alongside.
package dalu_pkg;
    typedef enum logic [1:0] {
        DALU_SCALE_NONE,
        DALU_SCALE_DOWN,
        DALU_SCALE_UP,
        DALU_SCALE_RSVD
    } dalu_scale_type;
    typedef enum logic [2:0] {
        DALU_OP_NOP,
        DALU_OP_MPY,
        DALU_OP_MAC,
        DALU_OP_MACN,
        DALU_OP_ADD,
        DALU_OP_SUB,
        DALU_OP_ASL,
        DALU_OP_ASR
    } dalu_op_type;
    typedef enum logic {
        DALU_IDLE,
        DALU_BUSY
    } dalu_state_type;
endpackage

// *** hdl/dalu_core.sv ***
// Data arithmetic unit: input registers, two 56-bit accumulators, MAC,
// accumulator shifter and two output shifter/limiters on the x/y operand buses.
// Assumes the sequencer drives ops and bus selects synchronously on clk_sys.
`timescale 1ns/1ns
`include "dalu_map.svh"
module dalu_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Scaling and error flag
    input wire logic [1:0] scaleMode,
    input wire logic limitErrClr,
    output logic limitErr,
    // Arithmetic command from the sequencer
    input wire logic opStart,
    input wire logic [2:0] opCode,
    input wire logic [1:0] opSrc1,
    input wire logic [1:0] opSrc2,
    input wire logic opDstB,
    output logic opBusy,
    output logic opDone,
    // X operand bus
    input wire logic xWrEn,
    input wire logic xRdEn,
    input wire logic [3:0] xSel,
    input wire logic [47:0] xWrData,
    output logic [47:0] xRdData,
    output logic xOverflow,
    // Y operand bus
    input wire logic yWrEn,
    input wire logic yRdEn,
    input wire logic [3:0] ySel,
    input wire logic [47:0] yWrData,
    output logic [47:0] yRdData,
    output logic yOverflow
);
    logic [23:0] inReg_q [4];
    logic [55:0] accA_q, accB_q;
    logic [55:0] accA_d, accB_d;
    logic limitErr_q;
    logic [47:0] xRd_q, yRd_q;
    logic xOvf_q, yOvf_q;
    dalu_pkg::dalu_state_type state_q;
    dalu_pkg::dalu_op_type opCode_q;
    logic [1:0] opSrc1_q, opSrc2_q;
    logic opDstB_q;

    // Fractional product: signed multiply, shift left one
    wire logic signed [23:0] mulA = inReg_q[opSrc1_q];
    wire logic signed [23:0] mulB = inReg_q[opSrc2_q];
    wire logic signed [47:0] rawProd = mulA * mulB;
    wire logic [55:0] fracProd = {{7{rawProd[47]}}, rawProd, 1'b0};
    wire logic [55:0] accDst = opDstB_q ? accB_q : accA_q;
    wire logic [55:0] accOther = opDstB_q ? accA_q : accB_q;
    logic [55:0] aluRes;
    always_comb begin
        case (opCode_q)
            dalu_pkg::DALU_OP_MPY: aluRes = fracProd;
            dalu_pkg::DALU_OP_MAC: aluRes = accDst + fracProd;
            dalu_pkg::DALU_OP_MACN: aluRes = accDst - fracProd;
            dalu_pkg::DALU_OP_ADD: aluRes = accDst + accOther;
            dalu_pkg::DALU_OP_SUB: aluRes = accDst - accOther;
            dalu_pkg::DALU_OP_ASL: aluRes = {accDst[54:0], 1'b0};
            dalu_pkg::DALU_OP_ASR: aluRes = {accDst[55], accDst[55:1]};
            default: aluRes = accDst;
        endcase
    end
    wire logic aluCommit = (state_q == dalu_pkg::DALU_BUSY);

    // Command taken on cycle 0, result committed on cycle 1
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= dalu_pkg::DALU_IDLE;
            opCode_q <= dalu_pkg::DALU_OP_NOP;
            opSrc1_q <= 2'h0;
            opSrc2_q <= 2'h0;
            opDstB_q <= 1'b0;
        end else begin
            case (state_q)
                dalu_pkg::DALU_IDLE: begin
                    if (opStart) begin
                        state_q <= dalu_pkg::DALU_BUSY;
                        opCode_q <= dalu_pkg::dalu_op_type'(opCode);
                        opSrc1_q <= opSrc1;
                        opSrc2_q <= opSrc2;
                        opDstB_q <= opDstB;
                    end
                end
                dalu_pkg::DALU_BUSY: state_q <= dalu_pkg::DALU_IDLE;
                default: state_q <= dalu_pkg::DALU_IDLE;
            endcase
        end
    end

    // Bus writes; x then y order, sign-extended on A, B, A0 and B0 writes
    function automatic logic [55:0] accWrite(input logic [55:0] cur, input logic [3:0] sel,
                                             input logic [3:0] base, input logic [47:0] data);
        logic [55:0] r;
        r = cur;
        if (sel == base)
            r = {{32{data[23]}}, data[23:0]};
        else if (sel == base + 4'h1)
            r = {cur[55:48], data[23:0], cur[23:0]};
        else if (sel == base + 4'h2)
            r = {data[7:0], cur[47:0]};
        return r;
    endfunction

    always_comb begin
        accA_d = accA_q;
        accB_d = accB_q;
        // MAC result lands first; a bus write to the same accumulator in that cycle overrides the bits it writes
        if (aluCommit && !opDstB_q)
            accA_d = aluRes;
        if (aluCommit && opDstB_q)
            accB_d = aluRes;
        if (xWrEn) begin
            accA_d = (xSel == `DALU_SEL_A) ? {{8{xWrData[47]}}, xWrData} : accWrite(accA_d, xSel, 4'h4, xWrData);
            accB_d = (xSel == `DALU_SEL_B) ? {{8{xWrData[47]}}, xWrData} : accWrite(accB_d, xSel, 4'h7, xWrData);
        end
        if (yWrEn) begin
            accA_d = (ySel == `DALU_SEL_A) ? {{8{yWrData[47]}}, yWrData} : accWrite(accA_d, ySel, 4'h4, yWrData);
            accB_d = (ySel == `DALU_SEL_B) ? {{8{yWrData[47]}}, yWrData} : accWrite(accB_d, ySel, 4'h7, yWrData);
        end
    end

    // Input register writes, 24-bit halves or 48-bit pairs
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                inReg_q[i] <= 24'h000000;
            end
            accA_q <= 56'h0;
            accB_q <= 56'h0;
        end else begin
            accA_q <= accA_d;
            accB_q <= accB_d;
            for (int i = 0; i < 4; i++) begin
                if (xWrEn && xSel == 4'(i))
                    inReg_q[i] <= xWrData[23:0];
                if (yWrEn && ySel == 4'(i))
                    inReg_q[i] <= yWrData[23:0];
            end
            if (xWrEn && xSel == `DALU_SEL_X) begin
                inReg_q[1] <= xWrData[47:24];
                inReg_q[0] <= xWrData[23:0];
            end
            if (xWrEn && xSel == `DALU_SEL_Y) begin
                inReg_q[3] <= xWrData[47:24];
                inReg_q[2] <= xWrData[23:0];
            end
            if (yWrEn && ySel == `DALU_SEL_X) begin
                inReg_q[1] <= yWrData[47:24];
                inReg_q[0] <= yWrData[23:0];
            end
            if (yWrEn && ySel == `DALU_SEL_Y) begin
                inReg_q[3] <= yWrData[47:24];
                inReg_q[2] <= yWrData[23:0];
            end
        end
    end

    function automatic logic [48:0] limitRead(input logic [3:0] sel, input logic [1:0] mode,
                                              input logic [55:0] a, input logic [55:0] b,
                                              input logic [23:0] r0, input logic [23:0] r1,
                                              input logic [23:0] r2, input logic [23:0] r3);
        logic [55:0] acc;
        logic [55:0] sh;
        logic fitsW, fitsL;
        logic [48:0] res;
        acc = (sel == `DALU_SEL_B0 || sel == `DALU_SEL_B1 || sel == `DALU_SEL_B2 || sel == `DALU_SEL_B) ? b : a;
        case (mode)
            2'h1: sh = {acc[55], acc[55:1]};
            2'h2: sh = {acc[54:0], 1'b0};
            default: sh = acc;
        endcase
        // Fits when extension bits plus sign agree
        fitsW = (sh[55:47] == {9{sh[47]}});
        fitsL = fitsW && !(mode == 2'h2 && acc[55] != acc[54]);
        res = {1'b0, 48'h0};
        case (sel)
            `DALU_SEL_X0: res = {1'b0, 24'h0, r0};
            `DALU_SEL_X1: res = {1'b0, 24'h0, r1};
            `DALU_SEL_Y0: res = {1'b0, 24'h0, r2};
            `DALU_SEL_Y1: res = {1'b0, 24'h0, r3};
            `DALU_SEL_X: res = {1'b0, r1, r0};
            `DALU_SEL_Y: res = {1'b0, r3, r2};
            `DALU_SEL_A0, `DALU_SEL_B0: res = {1'b0, 24'h0, acc[23:0]};
            `DALU_SEL_A2, `DALU_SEL_B2: res = {1'b0, {16{acc[55]}}, 24'h0, acc[55:48]} & 49'h00000000000ff;
            // Saturating 24 and 48 bit reads
            `DALU_SEL_A1, `DALU_SEL_B1:
                res = fitsL ? {1'b0, 24'h0, sh[47:24]} : {1'b1, 24'h0, (acc[55] ? `DALU_SAT_NEG : `DALU_SAT_POS)};
            `DALU_SEL_A, `DALU_SEL_B:
                // Polarity follows the source, as a scale-up may flip the shifted sign
                res = fitsL ? {1'b0, sh[47:0]} : {1'b1, (acc[55] ? `DALU_SAT_NEG48 : `DALU_SAT_POS48)};
            default: res = {1'b0, 48'h0};
        endcase
        return res;
    endfunction

    wire logic [48:0] xLim = limitRead(xSel, scaleMode, accA_q, accB_q,
                                       inReg_q[0], inReg_q[1], inReg_q[2], inReg_q[3]);
    wire logic [48:0] yLim = limitRead(ySel, scaleMode, accA_q, accB_q,
                                       inReg_q[0], inReg_q[1], inReg_q[2], inReg_q[3]);

    // Registered read data and overflow, one cycle after the read strobe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            xRd_q <= 48'h0;
            yRd_q <= 48'h0;
            xOvf_q <= 1'b0;
            yOvf_q <= 1'b0;
            limitErr_q <= 1'b0;
        end else begin
            xOvf_q <= xRdEn & xLim[48];
            yOvf_q <= yRdEn & yLim[48];
            if (xRdEn)
                xRd_q <= xLim[47:0];
            if (yRdEn)
                yRd_q <= yLim[47:0];
            // Sticky flag; a new overflow wins over the clear
            if ((xRdEn && xLim[48]) || (yRdEn && yLim[48]))
                limitErr_q <= 1'b1;
            else if (limitErrClr)
                limitErr_q <= 1'b0;
        end
    end

    assign xRdData = xRd_q;
    assign yRdData = yRd_q;
    assign xOverflow = xOvf_q;
    assign yOverflow = yOvf_q;
    assign limitErr = limitErr_q;
    assign opBusy = aluCommit;
    assign opDone = aluCommit;
endmodule

// *** test/dalu_core_sva.sv ***
// Checker for the data arithmetic unit: op timing, read outputs, limiter flag.
// Assumes binding to dalu_core and its single clk_sys domain.
`timescale 1ns/1ns
module dalu_core_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Error flag and ops
    input wire logic limitErrClr,
    input wire logic limitErr,
    input wire logic opStart,
    input wire logic opBusy,
    input wire logic opDone,
    // Operand buses
    input wire logic xRdEn,
    input wire logic [47:0] xRdData,
    input wire logic xOverflow,
    input wire logic yRdEn,
    input wire logic [47:0] yRdData,
    input wire logic yOverflow
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_op_busy_next: assert property (opStart && !opBusy |=> opBusy)
        else $error("op not busy after start");
    a_op_two_cycle: assert property (opBusy |=> !opBusy)
        else $error("op longer than two cycles");
    a_done_tracks_busy: assert property (opDone == opBusy)
        else $error("done and busy differ");
    a_done_after_start: assert property (opDone |-> $past(opStart && !opBusy))
        else $error("done without accepted start");
    a_xovf_from_read: assert property (!xRdEn |=> !xOverflow)
        else $error("x overflow without read");
    a_yovf_from_read: assert property (!yRdEn |=> !yOverflow)
        else $error("y overflow without read");
    a_xdata_held: assert property (!xRdEn |=> $stable(xRdData))
        else $error("x read data changed without read");
    a_ydata_held: assert property (!yRdEn |=> $stable(yRdData))
        else $error("y read data changed without read");
    a_ovf_saturates: assert property (
        xOverflow |-> xRdData[23:0] == 24'h7fffff || xRdData[23:0] == 24'h800000
        || xRdData == 48'h7fffffffffff || xRdData == 48'h800000000000)
        else $error("overflow without saturated value");
    a_yovf_saturates: assert property (
        yOverflow |-> yRdData == 48'h0000007fffff || yRdData == 48'h000000800000
        || yRdData == 48'h7fffffffffff || yRdData == 48'h800000000000)
        else $error("y overflow without saturated value");
    a_err_sticky: assert property (limitErr && !limitErrClr |=> limitErr)
        else $error("error flag dropped without clear");
    a_err_clear: assert property (
        limitErrClr && !xRdEn && !yRdEn && !xOverflow && !yOverflow |=> !limitErr)
        else $error("error flag not cleared");
    a_err_cause: assert property ($rose(limitErr) |-> $past(xRdEn || yRdEn) || $past(xRdEn || yRdEn, 2))
        else $error("error flag set without read");
endmodule

// *** test/dalu_seq_model.sv ***
// Sequencer model: issues arithmetic commands toward the unit.
// Assumes commands change on the falling edge of clk_sys.
`timescale 1ns/1ns
module dalu_seq_model (
    // Clock
    input wire logic clk_sys,
    // Command
    output logic opStart,
    output logic [2:0] opCode,
    output logic [1:0] opSrc1,
    output logic [1:0] opSrc2,
    output logic opDstB
);
    initial begin
        opStart = 1'b0;
        opCode = 3'h0;
        opSrc1 = 2'h0;
        opSrc2 = 2'h0;
        opDstB = 1'b0;
    end
    // One-cycle start, next op no sooner than two cycles later
    task automatic issue(input logic [2:0] c, input logic [1:0] s1, input logic [1:0] s2, input logic b);
        @(negedge clk_sys);
        opStart = 1'b1;
        opCode = c;
        opSrc1 = s1;
        opSrc2 = s2;
        opDstB = b;
        @(negedge clk_sys);
        opStart = 1'b0;
    endtask
endmodule

// *** test/tb_top.sv ***
// Testbench for the data arithmetic unit: bus moves, MAC, scaling, limiting.
// Assumes dalu_core, its package and the sequencer model are compiled first.
`timescale 1ns/1ns
module tb_top;
    logic clk_sys = 1'b0, resetn = 1'b0, limitErrClr = 1'b0;
    logic [1:0] scaleMode = 2'h0;
    logic xWrEn = 1'b0, xRdEn = 1'b0, yWrEn = 1'b0, yRdEn = 1'b0;
    logic [3:0] xSel = 4'h0, ySel = 4'h0;
    logic [47:0] xWrData = 48'h0, yWrData = 48'h0, xRdData, yRdData, rv;
    logic limitErr, opStart, opBusy, opDone, opDstB, xOverflow, yOverflow, ov;
    logic [2:0] opCode;
    logic [1:0] opSrc1, opSrc2;
    int err_count = 0, tests_run = 0, cyc = 0;
    always #2 clk_sys = ~clk_sys;
    dalu_seq_model dalu_seq_model_i (.clk_sys(clk_sys), .opStart(opStart), .opCode(opCode), .opSrc1(opSrc1),
        .opSrc2(opSrc2), .opDstB(opDstB));
    dalu_core dalu_core_i (.clk_sys(clk_sys), .resetn(resetn), .scaleMode(scaleMode), .limitErrClr(limitErrClr),
        .limitErr(limitErr), .opStart(opStart), .opCode(opCode), .opSrc1(opSrc1), .opSrc2(opSrc2), .opDstB(opDstB),
        .opBusy(opBusy), .opDone(opDone), .xWrEn(xWrEn), .xRdEn(xRdEn), .xSel(xSel), .xWrData(xWrData),
        .xRdData(xRdData), .xOverflow(xOverflow), .yWrEn(yWrEn), .yRdEn(yRdEn), .ySel(ySel), .yWrData(yWrData),
        .yRdData(yRdData), .yOverflow(yOverflow));
    task automatic chk(input logic [48:0] seen, input logic [48:0] exp, input string nm);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic onY, input logic [3:0] s, input logic [47:0] d);
        @(negedge clk_sys);
        {xWrEn, yWrEn, xSel, ySel, xWrData, yWrData} = {~onY, onY, s, s, d, d};
        @(negedge clk_sys);
        {xWrEn, yWrEn} = 2'b00;
    endtask
    task automatic rd(input logic onY, input logic [3:0] s, output logic [47:0] d, output logic o);
        @(negedge clk_sys);
        {xRdEn, yRdEn, xSel, ySel} = {~onY, onY, s, s};
        @(negedge clk_sys);
        {xRdEn, yRdEn} = 2'b00;
        d = onY ? yRdData : xRdData;
        o = onY ? yOverflow : xOverflow;
    endtask
    task automatic t_moves();
        wr(1'b0, 4'h0, 48'h400000);
        wr(1'b0, 4'h1, 48'h123456);
        wr(1'b1, 4'h2, 48'h400000);
        rd(1'b1, 4'h0, rv, ov);
        chk({rv, ov}, {48'h000000400000, 1'b0}, "x0 via y");
        rd(1'b0, 4'h2, rv, ov);
        chk({rv, ov}, {48'h000000400000, 1'b0}, "y0 via x");
        rd(1'b1, 4'hc, rv, ov);
        chk({rv, ov}, {48'h123456400000, 1'b0}, "x pair");
    endtask
    task automatic t_mac();
        dalu_seq_model_i.issue(3'h1, 2'h0, 2'h2, 1'b0);
        chk(49'({opBusy, opDone}), 49'h3, "busy and done");
        @(negedge clk_sys);
        chk(49'({opBusy, opDone}), 49'h0, "idle");
        rd(1'b0, 4'h5, rv, ov);
        chk({rv, ov}, {48'h000000200000, 1'b0}, "mpy a1");
        dalu_seq_model_i.issue(3'h2, 2'h0, 2'h2, 1'b0);
        @(negedge clk_sys);
        rd(1'b0, 4'ha, rv, ov);
        chk({rv, ov}, {48'h400000000000, 1'b0}, "mac A");
    endtask
    task automatic t_scale();
        logic [23:0] e [4] = '{24'h400000, 24'h200000, 24'h7fffff, 24'h400000};
        for (int m = 0; m < 4; m++) begin
            scaleMode = m[1:0];
            rd(1'b0, 4'h5, rv, ov);
            chk({rv, ov}, {24'h0, e[m], m == 2}, "scaled a1");
        end
        scaleMode = 2'h0;
        chk(49'(limitErr), 49'h1, "err set");
    endtask
    task automatic t_limit();
        wr(1'b1, 4'h6, 48'h01);
        rd(1'b0, 4'ha, rv, ov);
        chk({rv, ov}, {48'h7fffffffffff, 1'b1}, "pos limit");
        wr(1'b0, 4'h6, 48'hfe);
        rd(1'b1, 4'h5, rv, ov);
        chk({rv, ov}, {48'h000000800000, 1'b1}, "neg limit");
        repeat (2) @(negedge clk_sys);
        chk(49'(limitErr), 49'h1, "err held");
        limitErrClr = 1'b1;
        @(negedge clk_sys);
        limitErrClr = 1'b0;
        @(negedge clk_sys);
        chk(49'(limitErr), 49'h0, "err cleared");
    endtask
    // Remaining op codes except NOP, destination B and negative results
    task automatic t_ops();
        wr(1'b0, 4'ha, 48'h100000000000);
        wr(1'b1, 4'hb, 48'h080000000000);
        dalu_seq_model_i.issue(3'h4, 2'h0, 2'h0, 1'b0);
        @(negedge clk_sys);
        rd(1'b0, 4'ha, rv, ov);
        chk({rv, ov}, {48'h180000000000, 1'b0}, "add A");
        dalu_seq_model_i.issue(3'h5, 2'h0, 2'h0, 1'b1);
        @(negedge clk_sys);
        rd(1'b1, 4'h9, rv, ov);
        chk({rv, ov}, {48'h0000000000ff, 1'b0}, "sub b2");
        rd(1'b1, 4'hb, rv, ov);
        chk({rv, ov}, {48'hf00000000000, 1'b0}, "sub B");
        dalu_seq_model_i.issue(3'h6, 2'h0, 2'h0, 1'b1);
        @(negedge clk_sys);
        rd(1'b0, 4'h8, rv, ov);
        chk({rv, ov}, {48'h000000e00000, 1'b0}, "asl b1");
        dalu_seq_model_i.issue(3'h7, 2'h0, 2'h0, 1'b0);
        @(negedge clk_sys);
        rd(1'b0, 4'h5, rv, ov);
        chk({rv, ov}, {48'h0000000c0000, 1'b0}, "asr a1");
        dalu_seq_model_i.issue(3'h3, 2'h0, 2'h2, 1'b0);
        @(negedge clk_sys);
        rd(1'b1, 4'h5, rv, ov);
        chk({rv, ov}, {48'h000000ec0000, 1'b0}, "macn a1");
        dalu_seq_model_i.issue(3'h1, 2'h0, 2'h1, 1'b1);
        @(negedge clk_sys);
        rd(1'b1, 4'h8, rv, ov);
        chk({rv, ov}, {48'h000000091a2b, 1'b0}, "mpy b1");
        rd(1'b0, 4'h7, rv, ov);
        chk({rv, ov}, 49'h0, "mpy b0");
    endtask
    // Negative source under scale-up, then a reset in mid-run
    task automatic t_reset();
        wr(1'b0, 4'h6, 48'h80);
        scaleMode = 2'h2;
        rd(1'b0, 4'h5, rv, ov);
        scaleMode = 2'h0;
        chk({rv, ov}, {48'h000000800000, 1'b1}, "neg scaled limit");
        @(negedge clk_sys);
        resetn = 1'b0;
        @(negedge clk_sys);
        chk({xRdData, limitErr}, 49'h0, "x out in reset");
        chk({yRdData, opBusy}, 49'h0, "y out in reset");
        resetn = 1'b1;
        rd(1'b0, 4'ha, rv, ov);
        chk({rv, ov}, 49'h0, "A after reset");
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(negedge clk_sys);
        resetn = 1'b1;
        t_moves();
        t_mac();
        t_scale();
        t_limit();
        t_ops();
        t_reset();
        stop_test();
    end
endmodule
bind dalu_core dalu_core_sva dalu_core_sva_i (.clk_sys(clk_sys), .resetn(resetn), .limitErrClr(limitErrClr),
    .limitErr(limitErr), .opStart(opStart), .opBusy(opBusy), .opDone(opDone), .xRdEn(xRdEn),
    .xRdData(xRdData), .xOverflow(xOverflow), .yRdEn(yRdEn), .yRdData(yRdData), .yOverflow(yOverflow));
